/* src/mal_pkg.sv */
// Purpose: shared constants and state types of the motor alarm and edit-lock block
// Assumes: 200 MHz system clock
// Notes: alarm and warning codes are display codes, one byte each
package mal_pkg;

    // clock rate and timing figures
    localparam int CLK_MHZ = 200;
    localparam int KEY_HOLD_MS = 5000;
    localparam int LOCK_WARN_MS = 1000;
    localparam int KEY_HOLD_CYC = KEY_HOLD_MS * 1000 * CLK_MHZ;
    localparam int LOCK_WARN_CYC = LOCK_WARN_MS * 1000 * CLK_MHZ;

    // speed thresholds in r/min
    localparam logic [11:0] OVERSPEED_RPM = 12'h8FC;
    localparam logic [11:0] BRAKE_RPM = 12'h834;

    // alarm codes, zero means no alarm
    localparam logic [7:0] AL_NONE = 8'h00;
    localparam logic [7:0] AL_OVERHEAT = 8'h26;
    localparam logic [7:0] AL_LOCK = 8'h30;
    localparam logic [7:0] AL_OVERSPEED = 8'h31;
    localparam logic [7:0] AL_STORAGE = 8'h41;
    localparam logic [7:0] AL_POWERON = 8'h45;
    localparam logic [7:0] AL_EXT_STOP = 8'h5E;

    // warning codes
    localparam logic [7:0] WN_LOCK = 8'h30;
    localparam logic [7:0] WN_OP_ERR = 8'h6C;

    // history depth and power-on settle count
    localparam int HIST_DEPTH = 9;
    localparam logic [1:0] POR_SETTLE = 2'h3;

    // external fault contact is normally closed, so its synchroniser wakes at the idle level
    localparam logic [1:0] EXT_SY_RST = 2'h3;

    // reset values
    localparam logic [31:0] CNT_RST = 32'h0000_0000;

    typedef struct packed {
        logic [1:0] fwd_sy;
        logic [1:0] rev_sy;
        logic [1:0] clr_sy;
        logic [1:0] ext_sy;
        logic [1:0] th_sy;
        logic [1:0] lk_sy;
        logic clr_prev;
        logic inch_prev;
        logic [1:0] por_cnt;
        logic por_done;
        logic [7:0] alarm_code;
        logic [31:0] lock_cnt;
        logic [31:0] key_cnt;
        logic key_done;
        logic edit_lock;
        logic unlock_show;
        logic op_err;
        logic lock_warn;
        logic drive_en;
        logic brake;
        logic alarm_n;
        logic lamp;
        logic warn;
        logic thermal_state_output;
        logic edit_grant;
    } mal_state_t;

endpackage

/* src/mal_hist.sv */
// Purpose: newest-first code history held in flip-flops
// Assumes: push and clear are single-cycle pulses on the system clock
// Notes: entry 0 is newest; a push drops the oldest entry
`timescale 1ns/1ps
module mal_hist #(
    parameter int DEPTH = mal_pkg::HIST_DEPTH,
    parameter int IDX_W = 4
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // write side
    input wire logic push_i,
    input wire logic [7:0] code_i,
    input wire logic clear_i,
    // read side
    input wire logic [IDX_W-1:0] rd_idx_i,
    output logic [7:0] rd_code_o
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] entry;
        logic [7:0] rd_code;
    } mal_hist_t;

    mal_hist_t st;
    mal_hist_t next_st;
    logic [DEPTH-1:0][7:0] shifted;

    // one shift stage per entry, newest enters at zero
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_shift
            if (g == 0)
            begin : g_head
                assign shifted[g] = code_i;
            end
            else
            begin : g_tail
                assign shifted[g] = st.entry[g-1];
            end
        end
    endgenerate

    // clear wins over push: a clear command empties the whole record
    always_comb
    begin
        next_st = st;
        if (clear_i)
            next_st.entry = '0;
        else if (push_i)
            next_st.entry = shifted;
        // out-of-range index reads as no code
        if (int'(rd_idx_i) < DEPTH)
            next_st.rd_code = st.entry[rd_idx_i];
        else
            next_st.rd_code = 8'h00;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st <= '0;
        else if (clk_en_i)
            st <= next_st;
    end

    assign rd_code_o = st.rd_code;
endmodule

/* src/mal_top.sv */
// Purpose: alarm detection, alarm latch and history, warnings and edit-lock of a motor speed controller
// Assumes: one 200 MHz clock; pins pass two flip-flops; panel and sensor words are on-clock
// Notes on behaviour
// - edit requests refused while edit-lock active
// - 5 s key hold when unlocked locks
// - 5 s key hold when locked unlocks
// - any alarm removes drive, motor coasts
// - alarm drops alarm output, lamp, shows code
// - thermal protector open raises overheat alarm
// - shaft locked past set time raises alarm
// - speed above 2300 r/min raises overspeed
// - speed above 2100 r/min applies brake
// - storage fault alarm; clear input cannot clear
// - run input at power-on raises alarm
// - power-on alarm suppressed when disabled
// - assigned external fault inactive raises stop alarm
// - clear on rising edge of clear input
// - clear input ignored while run active
// - panel clear and power cycle also clear
// - nine-alarm history newest first, clearable
// - warning output follows warning condition
// - warning history lost at power off
// - lock warning after 1 s, keep running
// - run active leaving inch mode: warn, stop
`timescale 1ns/1ps
module mal_top #(
    parameter int KEY_HOLD_CYC = mal_pkg::KEY_HOLD_CYC,
    parameter int LOCK_WARN_CYC = mal_pkg::LOCK_WARN_CYC
) (
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // pins from outside, synchronised here
    input wire logic forward_run_input_i,
    input wire logic reverse_run_input_i,
    input wire logic fault_clear_i,
    input wire logic external_fault_input_i,
    input wire logic thermal_open_i,
    input wire logic shaft_locked_i,
    // on-clock sensor and status words
    input wire logic [11:0] shaft_speed_i,
    input wire logic storage_error_i,
    // parameters
    input wire logic [31:0] lock_time_cyc_i,
    input wire logic poweron_guard_en_i,
    input wire logic ext_fault_assigned_i,
    // operation panel
    input wire logic panel_key_i,
    input wire logic top_screen_i,
    input wire logic panel_alarm_clear_i,
    input wire logic history_clear_i,
    input wire logic manual_inch_mode_i,
    input wire logic edit_req_i,
    input wire logic [3:0] alarm_hist_idx_i,
    input wire logic [3:0] warn_hist_idx_i,
    // drive stage
    output logic drive_enable_o,
    output logic brake_o,
    // alarm and warning outputs
    output logic alarm_out_o,
    output logic fault_lamp_o,
    output logic [7:0] alarm_code_o,
    output logic warning_output_o,
    output logic thermal_state_output_o,
    output logic [7:0] alarm_hist_code_o,
    output logic [7:0] warn_hist_code_o,
    // edit-lock
    output logic edit_grant_o,
    output logic edit_lock_o,
    output logic lock_indicator_o,
    output logic unlock_indicator_o
);
    mal_pkg::mal_state_t st;
    mal_pkg::mal_state_t next_st;

    // synchronised pin levels, second stage only
    logic forward_run_input;
    logic reverse_run_input;
    logic clr;
    logic ext_ok;
    logic th_open;
    logic locked;
    logic run_any;
    logic clr_edge;
    logic [7:0] detect;
    logic alarm_push;
    logic lock_warn_now;
    logic inch_exit;
    logic warn_push;
    logic [7:0] warn_code;

    assign forward_run_input = st.fwd_sy[1];
    assign reverse_run_input = st.rev_sy[1];
    assign clr = st.clr_sy[1];
    assign ext_ok = st.ext_sy[1];
    assign th_open = st.th_sy[1];
    assign locked = st.lk_sy[1];
    assign run_any = forward_run_input | reverse_run_input;

    // clear edge counts only with both run inputs off
    assign clr_edge = clr & ~st.clr_prev & ~run_any;

    // fault detection, storage first since no input clear reaches it
    always_comb
    begin
        detect = mal_pkg::AL_NONE;
        if (storage_error_i)
            detect = mal_pkg::AL_STORAGE;
        else if (th_open)
            detect = mal_pkg::AL_OVERHEAT;
        else if (st.lock_cnt >= lock_time_cyc_i && lock_time_cyc_i != 32'h0000_0000)
            detect = mal_pkg::AL_LOCK;
        else if (shaft_speed_i > mal_pkg::OVERSPEED_RPM)
            detect = mal_pkg::AL_OVERSPEED;
        else if (ext_fault_assigned_i && !ext_ok)
            detect = mal_pkg::AL_EXT_STOP;
    end

    // warnings: lock held 1 s, or run input active when inch mode ends
    assign lock_warn_now = st.lock_cnt >= 32'(LOCK_WARN_CYC);
    assign inch_exit = st.inch_prev & ~manual_inch_mode_i & run_any;
    assign warn_push = (lock_warn_now & ~st.lock_warn) | inch_exit;
    assign warn_code = inch_exit ? mal_pkg::WN_OP_ERR : mal_pkg::WN_LOCK;

    // next-state logic for the whole block
    always_comb
    begin
        next_st = st;
        alarm_push = 1'b0;

        // two-stage synchronisers
        next_st.fwd_sy = {st.fwd_sy[0], forward_run_input_i};
        next_st.rev_sy = {st.rev_sy[0], reverse_run_input_i};
        next_st.clr_sy = {st.clr_sy[0], fault_clear_i};
        next_st.ext_sy = {st.ext_sy[0], external_fault_input_i};
        next_st.th_sy = {st.th_sy[0], thermal_open_i};
        next_st.lk_sy = {st.lk_sy[0], shaft_locked_i};
        next_st.clr_prev = clr;
        next_st.inch_prev = manual_inch_mode_i;

        // power-on check waits for the synchronisers to settle
        if (!st.por_done)
        begin
            if (st.por_cnt == mal_pkg::POR_SETTLE)
                next_st.por_done = 1'b1;
            else
                next_st.por_cnt = st.por_cnt + 2'h1;
        end

        // alarm latch: a detected fault wins over a clear in the same cycle
        if (st.alarm_code == mal_pkg::AL_NONE)
        begin
            if (detect != mal_pkg::AL_NONE)
                next_st.alarm_code = detect;
            else if (st.por_cnt == mal_pkg::POR_SETTLE && !st.por_done && run_any && poweron_guard_en_i)
                next_st.alarm_code = mal_pkg::AL_POWERON;
        end
        else if (st.alarm_code == mal_pkg::AL_POWERON)
        begin
            // run-prevention alarm ends when the run inputs drop
            if (!run_any || panel_alarm_clear_i || clr_edge)
                next_st.alarm_code = detect;
        end
        else if (panel_alarm_clear_i)
            next_st.alarm_code = detect;
        else if (clr_edge && st.alarm_code != mal_pkg::AL_STORAGE)
            next_st.alarm_code = detect;
        alarm_push = (st.alarm_code == mal_pkg::AL_NONE) && (next_st.alarm_code != mal_pkg::AL_NONE);

        // lock timer runs only while the motor is driven
        if (locked && st.drive_en)
        begin
            if (st.lock_cnt != 32'hFFFF_FFFF)
                next_st.lock_cnt = st.lock_cnt + 32'h0000_0001;
        end
        else
            next_st.lock_cnt = mal_pkg::CNT_RST;
        next_st.lock_warn = lock_warn_now;

        // operation error holds the motor stopped until both run inputs drop
        if (inch_exit)
            next_st.op_err = 1'b1;
        else if (!run_any)
            next_st.op_err = 1'b0;

        // key hold timer; one toggle per press
        if (panel_key_i && top_screen_i)
        begin
            if (!st.key_done)
            begin
                if (st.key_cnt >= 32'(KEY_HOLD_CYC) - 32'h0000_0001)
                begin
                    next_st.key_done = 1'b1;
                    next_st.key_cnt = mal_pkg::CNT_RST;
                    next_st.edit_lock = ~st.edit_lock;
                    next_st.unlock_show = st.edit_lock;
                end
                else
                    next_st.key_cnt = st.key_cnt + 32'h0000_0001;
            end
        end
        else
        begin
            next_st.key_cnt = mal_pkg::CNT_RST;
            next_st.key_done = 1'b0;
        end

        // edits pass only while unlocked
        next_st.edit_grant = edit_req_i & ~st.edit_lock;

        // registered outputs follow the latched alarm in one step
        // no drive before the power-on check has looked at the run pins
        next_st.drive_en = (forward_run_input ^ reverse_run_input) & (next_st.alarm_code == mal_pkg::AL_NONE) & ~next_st.op_err
            & next_st.por_done;
        next_st.alarm_n = next_st.alarm_code == mal_pkg::AL_NONE;
        next_st.lamp = next_st.alarm_code != mal_pkg::AL_NONE;
        // braking with or without drive, only below alarm, keeps overspeed away
        next_st.brake = (shaft_speed_i > mal_pkg::BRAKE_RPM) & (next_st.alarm_code == mal_pkg::AL_NONE);
        next_st.warn = lock_warn_now | next_st.op_err;
        next_st.thermal_state_output = th_open;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st <= '0;
            // a zero here would read as an open contact and latch a false stop
            st.ext_sy <= mal_pkg::EXT_SY_RST;
        end
        else if (clk_en_i)
            st <= next_st;
    end

    // alarm record, survives only as long as this block is powered
    mal_hist #(
        .DEPTH(mal_pkg::HIST_DEPTH),
        .IDX_W(4)
    ) u_alarm_hist (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .clk_en_i(clk_en_i),
        .push_i(alarm_push),
        .code_i(next_st.alarm_code),
        .clear_i(history_clear_i),
        .rd_idx_i(alarm_hist_idx_i),
        .rd_code_o(alarm_hist_code_o)
    );

    // warning record, volatile: only reset clears it
    mal_hist #(
        .DEPTH(mal_pkg::HIST_DEPTH),
        .IDX_W(4)
    ) u_warn_hist (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .clk_en_i(clk_en_i),
        .push_i(warn_push),
        .code_i(warn_code),
        .clear_i(1'b0),
        .rd_idx_i(warn_hist_idx_i),
        .rd_code_o(warn_hist_code_o)
    );

    // outputs from flip-flops, unlock indicator gated by the lock flop
    assign drive_enable_o = st.drive_en;
    assign brake_o = st.brake;
    assign alarm_out_o = st.alarm_n;
    assign fault_lamp_o = st.lamp;
    assign alarm_code_o = st.alarm_code;
    assign warning_output_o = st.warn;
    assign thermal_state_output_o = st.thermal_state_output;
    assign edit_grant_o = st.edit_grant;
    assign edit_lock_o = st.edit_lock;
    assign lock_indicator_o = st.edit_lock;
    assign unlock_indicator_o = st.unlock_show & ~st.edit_lock;
endmodule

/* sim/mal_top_sva.sv */
// Purpose: port checks of the alarm and edit-lock block
// Assumes: one clock domain, clock enable held high
// Notes: pin inputs pass a two-stage synchroniser first
`timescale 1ns/1ps
module mal_top_sva (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // inputs watched
    input wire logic storage_error_i,
    input wire logic forward_run_input_i,
    input wire logic [11:0] shaft_speed_i,
    input wire logic panel_alarm_clear_i,
    input wire logic edit_req_i,
    // outputs watched
    input wire logic [7:0] alarm_code_o,
    input wire logic alarm_out_o,
    input wire logic fault_lamp_o,
    input wire logic drive_enable_o,
    input wire logic brake_o,
    input wire logic edit_grant_o,
    input wire logic edit_lock_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // reset holds alarm_out low, so the first edge after release is skipped
    flags_match_a:
    assert property ($past(arst_n_i) |-> alarm_out_o == (alarm_code_o == 8'h00)
        && fault_lamp_o == (alarm_code_o != 8'h00)) else $error("alarm output or lamp disagrees with code");
    coast_on_alarm_a:
    assert property (alarm_code_o != 8'h00 |-> !drive_enable_o) else $error("drive on during alarm");
    storage_set_a:
    assert property (storage_error_i && alarm_code_o == 8'h00 |=> alarm_code_o == 8'h41)
        else $error("storage fault not latched");
    storage_hold_a:
    assert property (alarm_code_o == 8'h41 && !panel_alarm_clear_i |=> alarm_code_o == 8'h41)
        else $error("storage alarm left without panel clear");
    overspeed_set_a:
    assert property (shaft_speed_i > 12'h8FC && alarm_code_o == 8'h00 |=> alarm_code_o != 8'h00)
        else $error("overspeed not latched");
    brake_band_a:
    assert property (shaft_speed_i > 12'h834 && shaft_speed_i <= 12'h8FC && alarm_code_o == 8'h00
        && !storage_error_i |=> brake_o) else $error("brake not applied");
    // run pin must be seen through the synchroniser, hence four samples
    clear_blocked_a:
    assert property (forward_run_input_i [*4] ##0 (alarm_code_o != 8'h00 && !panel_alarm_clear_i)
        |=> $stable(alarm_code_o)) else $error("alarm changed while run input on");
    edit_gate_a:
    assert property (edit_req_i |=> edit_grant_o == !$past(edit_lock_o)) else $error("edit grant wrong");
    // main scenarios reached
    cover property (alarm_code_o == 8'h41);
    cover property ($rose(edit_lock_o));
    cover property ($rose(brake_o));
endmodule
bind mal_top mal_top_sva i_mal_top_sva (.sys_clk_i, .arst_n_i, .storage_error_i, .forward_run_input_i,
    .shaft_speed_i, .panel_alarm_clear_i, .edit_req_i, .alarm_code_o, .alarm_out_o, .fault_lamp_o,
    .drive_enable_o, .brake_o, .edit_grant_o, .edit_lock_o);

/* sim/mal_motor_model.sv */
// Purpose: far-side motor and shaft sensor model
// Assumes: speed settles in one cycle, no inertia
// Notes: a forced speed stands for a load turning the shaft
`timescale 1ns/1ps
module mal_motor_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // drive stage and bench controls
    input wire logic drive_en_i,
    input wire logic jam_i,
    input wire logic [11:0] force_rpm_i,
    // sensor outputs
    output logic [11:0] rpm_o,
    output logic locked_o
);
    // a forced speed wins, as an outside load would; a jam only counts while driven
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rpm_o <= 12'h000;
            locked_o <= 1'b0;
        end
        else
        begin
            rpm_o <= (force_rpm_i != 12'h000) ? force_rpm_i : ((drive_en_i && !jam_i) ? 12'h4B0 : 12'h000);
            locked_o <= jam_i && drive_en_i;
        end
    end
endmodule

/* sim/mal_top_test.sv */
// Purpose: self-checking bench of the alarm and edit-lock block
// Assumes: key hold and lock warning counts shortened by parameter
// Notes: fault causes run as table rows, odd cases by hand after
`timescale 1ns/1ps
module mal_top_test;
    localparam int KEY = 20;
    typedef struct packed {logic th; logic st; logic xf; logic [11:0] spd; logic [7:0] code;} mal_row_t;
    // one row a cause: thermal, storage, overspeed, external stop
    mal_row_t rows [4] = '{'{1'b1, 1'b0, 1'b0, 12'h000, 8'h26}, '{1'b0, 1'b1, 1'b0, 12'h000, 8'h41},
        '{1'b0, 1'b0, 1'b0, 12'h8FD, 8'h31}, '{1'b0, 1'b0, 1'b1, 12'h000, 8'h5E}};
    logic sys_clk_i = 1'b0, arst_n_i = 1'b0, run_f = 1'b1, run_r = 1'b0, clr = 1'b0, ext_ok = 1'b1;
    logic th = 1'b0, st = 1'b0, jam = 1'b0, guard = 1'b1, key = 1'b0, pan = 1'b0, hclr = 1'b0, inch = 1'b0;
    logic scr = 1'b1, ereq = 1'b1;
    logic locked, drv, brk, aout, lamp, warn, thout, grant, lock, lki, uli;
    logic [3:0] hidx = 4'h0;
    logic [11:0] push = 12'h000, rpm;
    logic [7:0] code, hcode, wcode;
    int err_count = 0, cmp_count = 0;
    // design with short counts; lock alarm after 30 cycles
    mal_top #(.KEY_HOLD_CYC(KEY), .LOCK_WARN_CYC(10)) i_mal_top (.sys_clk_i, .arst_n_i, .clk_en_i(1'b1),
        .forward_run_input_i(run_f), .reverse_run_input_i(run_r), .fault_clear_i(clr),
        .external_fault_input_i(ext_ok), .thermal_open_i(th), .shaft_locked_i(locked), .shaft_speed_i(rpm),
        .storage_error_i(st), .lock_time_cyc_i(32'h0000_001E), .poweron_guard_en_i(guard),
        .ext_fault_assigned_i(1'b1), .panel_key_i(key), .top_screen_i(scr), .panel_alarm_clear_i(pan),
        .history_clear_i(hclr), .manual_inch_mode_i(inch), .edit_req_i(ereq), .alarm_hist_idx_i(hidx),
        .warn_hist_idx_i(hidx), .drive_enable_o(drv), .brake_o(brk), .alarm_out_o(aout), .fault_lamp_o(lamp),
        .alarm_code_o(code), .warning_output_o(warn), .thermal_state_output_o(thout),
        .alarm_hist_code_o(hcode), .warn_hist_code_o(wcode), .edit_grant_o(grant), .edit_lock_o(lock),
        .lock_indicator_o(lki), .unlock_indicator_o(uli));
    mal_motor_model i_mal_motor_model (.sys_clk_i, .arst_n_i, .drive_en_i(drv), .jam_i(jam),
        .force_rpm_i(push), .rpm_o(rpm), .locked_o(locked));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic ck(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // bounded wait for the lock state; running out ends the run
    task automatic wait_lock(input logic v);
        int n;
        for (n = 0; n < KEY + 8 && lock !== v; n++)
        begin
            cyc(1);
            #1;
        end
        if (lock !== v)
        begin
            err_count++;
            summarize();
        end
    endtask
    initial
    begin
        cyc(2);
        #1 ck({5'h00, aout, lamp, drv}, 8'h00);
        cyc(1);
        arst_n_i <= 1'b1;
        cyc(6);
        #1 ck(code, 8'h45);
        cyc(1);
        run_f <= 1'b0;
        cyc(5);
        #1 ck(code, 8'h00);
        $display("power-on test done");
        foreach (rows[i])
        begin
            cyc(1);
            run_f <= 1'b1;
            cyc(5);
            #1 ck({7'h00, drv}, 8'h01);
            cyc(1);
            th <= rows[i].th;
            st <= rows[i].st;
            ext_ok <= !rows[i].xf;
            push <= rows[i].spd;
            cyc(7);
            #1 ck(code, rows[i].code);
            ck({4'h0, thout, aout, lamp, drv}, {4'h0, rows[i].th, 3'b010});
            ck(hcode, rows[i].code);
            cyc(1);
            {th, st, ext_ok, push, clr} <= {3'b001, 12'h000, 1'b1};
            cyc(5);
            run_f <= 1'b0;
            #1 ck(code, rows[i].code);
            cyc(5);
            clr <= 1'b0;
            #1 ck(code, rows[i].code);
            cyc(2);
            clr <= 1'b1;
            cyc(5);
            #1 ck(code, rows[i].st ? rows[i].code : 8'h00);
            cyc(1);
            pan <= 1'b1;
            clr <= 1'b0;
            cyc(1);
            pan <= 1'b0;
            cyc(2);
            #1 ck(code, 8'h00);
        end
        $display("fault table done");
        // brake band edge: 0x835 brakes, 0x834 does not
        push <= 12'h835;
        cyc(3);
        #1 ck({6'h00, brk, |code}, 8'h02);
        cyc(1);
        push <= 12'h834;
        cyc(3);
        #1 ck({6'h00, brk, |code}, 8'h00);
        push <= 12'h000;
        run_f <= 1'b1;
        cyc(5);
        jam <= 1'b1;
        cyc(20);
        #1 ck({5'h00, warn, drv, |code}, 8'h06);
        ck(wcode, 8'h30);
        cyc(20);
        #1 ck(code, 8'h30);
        ck({6'h00, warn, drv}, 8'h00);
        {jam, run_f, pan} <= 3'b001;
        cyc(1);
        pan <= 1'b0;
        inch <= 1'b1;
        run_r <= 1'b1;
        cyc(5);
        inch <= 1'b0;
        cyc(3);
        #1 ck({6'h00, warn, drv}, 8'h02);
        ck(wcode, 8'h6C);
        run_r <= 1'b0;
        cyc(4);
        #1 ck({7'h00, warn}, 8'h00);
        $display("warning test done");
        key <= 1'b1;
        cyc(KEY - 3);
        #1 ck({6'h00, lock, grant}, 8'h01);
        wait_lock(1'b1);
        cyc(1);
        key <= 1'b0;
        cyc(1);
        #1 ck({4'h0, lock, lki, uli, grant}, 8'h0C);
        cyc(2);
        key <= 1'b1;
        wait_lock(1'b0);
        cyc(2);
        #1 ck({4'h0, lock, lki, uli, grant}, 8'h03);
        // key held away from the top screen must not toggle; no request, no grant
        {key, scr, ereq} <= 3'b100;
        cyc(KEY + 2);
        #1 ck({6'h00, lock, grant}, 8'h00);
        {key, scr, ereq} <= 3'b011;
        hidx <= 4'h1;
        cyc(2);
        #1 ck(hcode, 8'h5E);
        hidx <= 4'h9;
        cyc(2);
        #1 ck(hcode, 8'h00);
        {hidx, hclr} <= 5'h01;
        cyc(1);
        hclr <= 1'b0;
        cyc(2);
        #1 ck(hcode, 8'h00);
        ck(wcode, 8'h6C);
        $display("panel test done");
        {guard, run_f, arst_n_i} <= 3'b010;
        cyc(3);
        arst_n_i <= 1'b1; // power cycle only long after the last alarm
        cyc(8);
        #1 ck({6'h00, |code, drv}, 8'h01);
        ck(wcode, 8'h00);
        $display("power cycle test done");
        summarize();
    end
endmodule
